// ---- hw/lui_host_port.sv ----
// lui_host_port: host serial port, interrupt pin, hardware-mode pin decode
// assumes the serial pins are asynchronous and the ahb master is on I_CLK
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Function
// - a read frame shifts the addressed command register out on the data pin
// - serial output changes only on falling edges of the host serial clock
// - the serial output is released after the last read bit
// - in pin mode the serial output pin is the monitor-mode input
// - register reset low holds command registers, and config in host mode, at defaults
// - a new interrupt drives the active-low interrupt pin from high to low
// - interrupt enable bit cleared suppresses the interrupt pin
// - interrupt pin stays low until the host reads the alarm register
// - in pin mode the interrupt pin is the loss-of-signal mute input
// - in pin mode select pins give 16-bit, 32-bit fifo or attenuator off
// - serial write data is sampled on rising serial clock edges
module lui_host_port
  import lui_pkg::*;
#(
  parameter int NCH = 2
) (
  // clock and reset
  input  wire logic           I_CLK,
  input  wire logic           I_RST_N,
  // host serial port and straps
  input  wire logic           I_CS_N,
  input  wire logic           I_SCLK,
  input  wire logic           I_SERIAL_WRITE_IN,
  input  wire logic           I_REG_RESET_N,
  input  wire logic           I_CONTROL_STYLE_STRAP,
  // serial output pin, shared with monitor select
  input  wire logic           I_SERIAL_READ_OUT,
  output logic                O_SERIAL_READ_OUT,
  output logic                O_SERIAL_READ_OUT_OE_N,
  // interrupt pin, shared with loss mute
  input  wire logic           I_INT_N,
  output logic                O_INT_N,
  output logic                O_INT_OE_N,
  // attenuator pins
  input  wire logic           I_ATTEN_SELECT_LOW,
  input  wire logic           I_ATTEN_SELECT_HIGH,
  input  wire logic           I_ATTEN_PATH_SELECT,
  // line side
  input  wire logic [NCH-1:0] I_ALARM,
  output lui_cfg_t            O_CFG,
  // ahb-lite slave
  input  wire logic           HSEL,
  input  wire logic [31:0]    HADDR,
  input  wire logic [1:0]     HTRANS,
  input  wire logic           HWRITE,
  input  wire logic [2:0]     HSIZE,
  input  wire logic [31:0]    HWDATA,
  input  wire logic           HREADY,
  output logic [31:0]         HRDATA,
  output logic                HREADYOUT,
  output logic                HRESP,
  output logic                O_IRQ
);

  lui_pins_t      pin_meta;
  lui_pins_t      pin;
  logic           sclk_d;
  logic [7:0]     creg [LUI_NREG];
  logic [NCH-1:0] alarm_d;
  logic [NCH-1:0] alarm_lat;
  logic [4:0]     bit_cnt;
  logic [7:0]     cmd;
  logic [7:0]     wdata;
  logic           wr_pulse;
  logic           rd_pulse;
  logic           int_pulse;
  logic           alarm_clr;
  logic [2:0]     status;
  logic [2:0]     mask;
  logic           ap_valid;
  logic           ap_write;
  logic [7:0]     ap_addr;
  logic           host_mode;
  logic           sclk_rise;
  logic           sclk_fall;
  logic           in_frame;
  logic           reg_rst;
  logic [2:0]     addr;
  logic           is_rd;
  logic           int_want;
  logic [2:0]     ev;
  logic           take;
  logic           rd_status;
  logic [7:0]     next_cfg;
  logic [7:0]     rd_byte;
  logic [7:0]     rd_hold;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta <= '0;
      pin      <= '0;
      sclk_d   <= 1'b0;
    end else begin
      pin_meta <= {I_CS_N, I_SCLK, I_SERIAL_WRITE_IN, I_SERIAL_READ_OUT,
                   I_INT_N, I_ATTEN_SELECT_LOW, I_ATTEN_SELECT_HIGH,
                   I_ATTEN_PATH_SELECT, I_CONTROL_STYLE_STRAP,
                   I_REG_RESET_N};
      pin      <= pin_meta;
      sclk_d   <= pin.sclk;
    end
  end

  assign host_mode = pin.strap;
  assign in_frame  = !pin.cs_n && host_mode;
  assign sclk_rise = in_frame && pin.sclk && !sclk_d;
  assign sclk_fall = in_frame && !pin.sclk && sclk_d;
  assign reg_rst   = !pin.reg_rst_n;
  assign addr      = cmd[2:0];
  assign is_rd     = cmd[LUI_CMD_RD];

  // frame sequencing; a frame cut short by chip select is simply dropped
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_cnt <= '0;
      cmd     <= '0;
      wdata   <= '0;
    end else if (!in_frame) begin
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      if (bit_cnt < LUI_CMD_BITS) begin
        cmd <= {cmd[6:0], pin.serial_write_in};
      end else begin
        wdata <= {wdata[6:0], pin.serial_write_in};
      end
      if (bit_cnt < LUI_FRAME_BITS) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  assign wr_pulse = sclk_rise && !is_rd && bit_cnt == LUI_FRAME_BITS - 5'h01;
  assign rd_pulse = sclk_fall && is_rd && bit_cnt == LUI_CMD_BITS;
  assign alarm_clr = rd_pulse && addr == LUI_CREG_ALARM;
  assign rd_byte   = (addr == LUI_CREG_ALARM) ? 8'(alarm_lat) : creg[addr];

  // snapshot at the first data bit: the alarm latches clear on that edge,
  // so the later bits must not look at the live latches
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_hold <= '0;
    end else if (rd_pulse) begin
      rd_hold <= rd_byte;
    end
  end

  // command registers; the alarm slot is not writable
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < LUI_NREG; i++) begin
        creg[i] <= LUI_GEN_RST;
      end
      creg[LUI_CREG_CTRL] <= LUI_CTRL_RST;
      creg[LUI_CREG_CFG]  <= LUI_CFG_RST;
    end else if (reg_rst) begin
      for (int i = 0; i < LUI_NREG; i++) begin
        creg[i] <= LUI_GEN_RST;
      end
      creg[LUI_CREG_CTRL] <= LUI_CTRL_RST;
      creg[LUI_CREG_CFG]  <= LUI_CFG_RST;
    end else if (wr_pulse && addr != LUI_CREG_ALARM) begin
      creg[addr] <= {wdata[6:0], pin.serial_write_in};
    end
  end

  // serial output: bit k of the data phase goes out on falling edge k
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SERIAL_READ_OUT      <= 1'b0;
      O_SERIAL_READ_OUT_OE_N <= 1'b1;
    end else if (!in_frame) begin
      O_SERIAL_READ_OUT_OE_N <= 1'b1;
    end else if (sclk_fall && is_rd) begin
      if (bit_cnt >= LUI_CMD_BITS && bit_cnt < LUI_FRAME_BITS) begin
        O_SERIAL_READ_OUT <= (bit_cnt == LUI_CMD_BITS)
          ? rd_byte[7]
          : rd_hold[3'(LUI_FRAME_BITS - 5'h01 - bit_cnt)];
        O_SERIAL_READ_OUT_OE_N <= 1'b0;
      end else if (bit_cnt == LUI_FRAME_BITS) begin
        O_SERIAL_READ_OUT_OE_N <= 1'b1;
      end
    end
  end

  // alarms latch on a rising edge and hold until the host reads them;
  // a new edge in the clearing cycle survives
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      alarm_d   <= '0;
      alarm_lat <= '0;
    end else begin
      alarm_d <= I_ALARM;
      if (reg_rst) begin
        alarm_lat <= '0;
      end else begin
        alarm_lat <= (alarm_lat & {NCH{!alarm_clr}})
                   | (I_ALARM & ~alarm_d);
      end
    end
  end

  assign int_want = host_mode && (|alarm_lat)
                  && creg[LUI_CREG_CTRL][LUI_CTRL_IE];
  assign int_pulse = int_want && O_INT_N && host_mode;

  // push-pull interrupt pin, driven high and low in host mode, input in pin mode
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_INT_N    <= 1'b1;
      O_INT_OE_N <= 1'b1;
    end else begin
      O_INT_N    <= !int_want;
      O_INT_OE_N <= !host_mode;
    end
  end

  // configuration: registers in host mode, pins in pin mode
  assign next_cfg = creg[LUI_CREG_CFG];
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CFG <= '{1'b0, 1'b0, LUI_JA_FIFO16, 1'b0};
    end else if (!host_mode) begin
      O_CFG.rx_monitor <= pin.sdo_in;
      O_CFG.loss_mute  <= pin.int_in;
      O_CFG.ja_mode    <= pin.ja_lo ? LUI_JA_OFF
                        : (pin.ja_hi ? LUI_JA_FIFO32 : LUI_JA_FIFO16);
      O_CFG.ja_in_tx   <= pin.path;
    end else begin
      O_CFG.rx_monitor <= next_cfg[LUI_CFG_RECEIVER_MONITOR_SELECT];
      O_CFG.loss_mute  <= next_cfg[LUI_CFG_LOSMT];
      O_CFG.ja_mode    <= next_cfg[LUI_CFG_JA_LO] ? LUI_JA_OFF
                        : (next_cfg[LUI_CFG_JA_HI] ? LUI_JA_FIFO32
                                                   : LUI_JA_FIFO16);
      O_CFG.ja_in_tx   <= next_cfg[LUI_CFG_PATH];
    end
  end

  // ahb-lite slave, zero wait states, read data registered at address phase
  assign take      = HSEL && HREADY && HTRANS[1];
  assign rd_status = take && !HWRITE && HADDR[7:0] == LUI_A_STATUS;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      ap_valid  <= take && HWRITE;
      ap_write  <= HWRITE;
      ap_addr   <= HADDR[7:0];
      if (take && !HWRITE) begin
        case (HADDR[7:0])
          LUI_A_STATUS: HRDATA <= {29'h0, status};
          LUI_A_MASK:   HRDATA <= {29'h0, mask};
          LUI_A_VIEW:   HRDATA <= {25'h0, O_INT_N, host_mode,
                                   O_CFG.ja_in_tx, O_CFG.ja_mode,
                                   O_CFG.loss_mute, O_CFG.rx_monitor};
          default:      HRDATA <= '0;
        endcase
      end else begin
        HRDATA <= '0;
      end
    end
  end

  // sticky events, cleared by reading; a set in the same cycle wins
  assign ev = {int_pulse, rd_pulse, wr_pulse};
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status <= '0;
      mask   <= LUI_MASK_RST;
      O_IRQ  <= 1'b0;
    end else begin
      status <= (status & {3{!rd_status}}) | ev;
      if (ap_valid && ap_write && ap_addr == LUI_A_MASK) begin
        mask <= HWDATA[2:0];
      end
      O_IRQ <= |(status & mask);
    end
  end

endmodule

// ---- hw/lui_pkg.sv ----
// lui_pkg: constants and types for the host serial port and attenuator block
// assumes a 100 MHz system clock and a slow host serial clock
package lui_pkg;
  // command registers behind the serial port
  localparam int          LUI_NREG       = 8;
  localparam logic [2:0]  LUI_CREG_CTRL  = 3'h0; // channel control
  localparam logic [2:0]  LUI_CREG_ALARM = 3'h1; // latched alarms, read only
  localparam logic [2:0]  LUI_CREG_CFG   = 3'h2; // operating configuration
  localparam logic [7:0]  LUI_CTRL_RST   = 8'h00;
  localparam logic [7:0]  LUI_CFG_RST    = 8'h00;
  localparam logic [7:0]  LUI_GEN_RST    = 8'h00;
  localparam int          LUI_CTRL_IE    = 0;
  localparam int          LUI_CFG_RECEIVER_MONITOR_SELECT  = 0;
  localparam int          LUI_CFG_LOSMT  = 1;
  localparam int          LUI_CFG_JA_LO  = 2;
  localparam int          LUI_CFG_JA_HI  = 3;
  localparam int          LUI_CFG_PATH   = 4;
  // serial frame: 8 command bits (read flag in bit 7, address in bits 2:0), 8 data bits
  localparam logic [4:0]  LUI_CMD_BITS   = 5'h08;
  localparam logic [4:0]  LUI_FRAME_BITS = 5'h10;
  localparam int          LUI_CMD_RD     = 7;
  // ahb register map, byte addresses
  localparam logic [7:0]  LUI_A_STATUS   = 8'h00;
  localparam logic [7:0]  LUI_A_MASK     = 8'h04;
  localparam logic [7:0]  LUI_A_VIEW     = 8'h08;
  localparam logic [2:0]  LUI_MASK_RST   = 3'h0;
  localparam int          LUI_EV_WR      = 0;
  localparam int          LUI_EV_RD      = 1;
  localparam int          LUI_EV_INT     = 2;

  typedef enum logic [1:0] {
    LUI_JA_FIFO16,
    LUI_JA_FIFO32,
    LUI_JA_OFF
  } lui_ja_mode_t;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic serial_write_in;
    logic sdo_in;
    logic int_in;
    logic ja_lo;
    logic ja_hi;
    logic path;
    logic strap;
    logic reg_rst_n;
  } lui_pins_t;

  // configuration seen by the line side
  typedef struct packed {
    logic         rx_monitor;
    logic         loss_mute;
    lui_ja_mode_t ja_mode;
    logic         ja_in_tx;
  } lui_cfg_t;
endpackage

// ---- bench/lui_host_port_chk.sv ----
// lui_host_port_chk: pin level checks on the host serial port
// assumes it is bound to lui_host_port with the pins asynchronous to I_CLK
`timescale 1ns/1ps
module lui_host_port_chk
  import lui_pkg::*;
(
  // clock and reset
  input wire logic     I_CLK,
  input wire logic     I_RST_N,
  // pins watched
  input wire logic     I_CS_N,
  input wire logic     I_SCLK,
  input wire logic     I_REG_RESET_N,
  input wire logic     I_CONTROL_STYLE_STRAP,
  input wire logic     I_INT_N,
  input wire logic     I_ATTEN_SELECT_LOW,
  input wire logic     I_ATTEN_PATH_SELECT,
  input wire logic     O_SERIAL_READ_OUT,
  input wire logic     O_SERIAL_READ_OUT_OE_N,
  input wire logic     O_INT_N,
  input wire logic     O_INT_OE_N,
  input wire lui_cfg_t O_CFG
);
  logic       sclk_q;
  logic [3:0] fall_age;
  // saturating age of the last serial clock fall, so it never wraps
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_q   <= 1'b0;
      fall_age <= 4'hf;
    end else begin
      sclk_q <= I_SCLK;
      if (sclk_q && !I_SCLK) fall_age <= 4'h0;
      else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // pin mode needs the strap through its synchroniser first
  sequence pin_mode_s;
    (!I_CONTROL_STYLE_STRAP)[*4];
  endsequence
  AST_SDO_ON_FALL: assert property (
    !O_SERIAL_READ_OUT_OE_N && $changed(O_SERIAL_READ_OUT) |-> fall_age < 7)
    else $error("serial output changed away from a clock fall");
  AST_SDO_RELEASE: assert property (
    I_CS_N[*4] |=> O_SERIAL_READ_OUT_OE_N)
    else $error("serial output driven outside a frame");
  AST_SDO_PIN_MODE: assert property (
    pin_mode_s |=> O_SERIAL_READ_OUT_OE_N)
    else $error("serial output driven in pin mode");
  AST_REG_RESET: assert property (
    (I_CONTROL_STYLE_STRAP && !I_REG_RESET_N)[*6] |=> O_CFG == '0 && O_INT_N)
    else $error("register reset left a setting active");
  AST_INT_FALL: assert property (
    $fell(O_INT_N) |-> !O_INT_OE_N)
    else $error("interrupt asserted while pin not driven");
  AST_MUTE_PIN: assert property (
    pin_mode_s and (I_INT_N)[*4] |=> O_INT_OE_N && O_CFG.loss_mute)
    else $error("interrupt pin not acting as mute input");
  AST_JA_OFF: assert property (
    pin_mode_s and I_ATTEN_SELECT_LOW[*4] |=> O_CFG.ja_mode == LUI_JA_OFF)
    else $error("attenuator not disabled by select pins");
  AST_JA_PATH: assert property (
    pin_mode_s and I_ATTEN_PATH_SELECT[*4] |=> O_CFG.ja_in_tx)
    else $error("attenuator not in transmit path");
endmodule
bind lui_host_port lui_host_port_chk chk_u (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_SCLK(I_SCLK),
  .I_REG_RESET_N(I_REG_RESET_N), .I_INT_N(I_INT_N),
  .I_CONTROL_STYLE_STRAP(I_CONTROL_STYLE_STRAP),
  .I_ATTEN_SELECT_LOW(I_ATTEN_SELECT_LOW),
  .I_ATTEN_PATH_SELECT(I_ATTEN_PATH_SELECT),
  .O_SERIAL_READ_OUT(O_SERIAL_READ_OUT),
  .O_SERIAL_READ_OUT_OE_N(O_SERIAL_READ_OUT_OE_N),
  .O_INT_N(O_INT_N), .O_INT_OE_N(O_INT_OE_N), .O_CFG(O_CFG));

// ---- bench/lui_host_mcu.sv ----
// lui_host_mcu: behavioural serial host driving chip select, clock and data
// assumes a 160 ns serial clock that stands still low between frames
`timescale 1ns/1ps
module lui_host_mcu (
  // serial master pins
  output logic     o_cs_n,
  output logic     o_sclk,
  output logic     o_sdi,
  // serial read pin as resolved on the board
  input  wire logic i_sdo
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end
  // one frame, command byte then data byte, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    #3 o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = sh[i];
      #80 o_sclk = 1'b1;
      if (i < 8) rd[i] = i_sdo;
      #80 o_sclk = 1'b0;
    end
    // data line no longer meaningful: show the opposite level
    o_sdi = ~o_sdi;
    #80 o_cs_n = 1'b1;
    #100;
  endtask
endmodule

// ---- bench/tb.sv ----
// tb: host port bench with ahb master tasks and a serial host model
// assumes a 100 MHz clock; serial clock comes from lui_host_mcu
`timescale 1ns/1ps
module tb;
  import lui_pkg::*;
  logic        I_CLK, I_RST_N, I_REG_RESET_N, I_CONTROL_STYLE_STRAP;
  logic        I_CS_N, I_SCLK, I_SERIAL_WRITE_IN;
  logic        I_ATTEN_SELECT_LOW, I_ATTEN_SELECT_HIGH, I_ATTEN_PATH_SELECT;
  logic [1:0]  I_ALARM, HTRANS;
  logic        HSEL, HWRITE, HREADYOUT, HRESP, O_IRQ;
  logic [2:0]  HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, r;
  logic        O_SERIAL_READ_OUT, O_SERIAL_READ_OUT_OE_N, O_INT_N, O_INT_OE_N;
  lui_cfg_t    O_CFG;
  logic        sdo_last, mon_drv, mute_drv;
  logic [7:0]  s;
  int          bad_count, total_checks;
  wire         HREADY = HREADYOUT;
  // released pins: opposite of last level in host mode, board level otherwise
  wire I_SERIAL_READ_OUT = !O_SERIAL_READ_OUT_OE_N ? O_SERIAL_READ_OUT :
                           (I_CONTROL_STYLE_STRAP ? ~sdo_last : mon_drv);
  wire I_INT_N = !O_INT_OE_N ? O_INT_N : mute_drv;
  lui_host_port dut_u (.*);
  lui_host_mcu host_u (.o_cs_n(I_CS_N), .o_sclk(I_SCLK),
                       .o_sdi(I_SERIAL_WRITE_IN), .i_sdo(I_SERIAL_READ_OUT));
  always #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK)
    if (!O_SERIAL_READ_OUT_OE_N) sdo_last <= O_SERIAL_READ_OUT;
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("FAIL %s exp %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  // one ahb-lite single word transfer; waits on hready, bounded
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {24'h0, a};
    do @(posedge I_CLK); while (!HREADY && ++n < 50);
    HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge I_CLK); while (!HREADY && ++n < 50);
    r = HRDATA;
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
  endtask
  initial begin
    {I_CLK, I_RST_N, I_ALARM, HSEL, HTRANS, HWRITE, HADDR, HWDATA} = '0;
    {I_ATTEN_SELECT_LOW, I_ATTEN_SELECT_HIGH, I_ATTEN_PATH_SELECT} = '0;
    {sdo_last, mon_drv, mute_drv, bad_count, total_checks} = '0;
    {I_REG_RESET_N, I_CONTROL_STYLE_STRAP} = 2'h3;
    HSIZE = 3'h2;
    repeat (5) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    repeat (5) @(posedge I_CLK);
    ahb(1'b0, LUI_A_VIEW, 32'h0); chk("view", r, 32'h60);
    ahb(1'b1, LUI_A_MASK, 32'h3); ahb(1'b0, LUI_A_MASK, 32'h0);
    chk("mask", r, 32'h3);
    ahb(1'b0, 8'h40, 32'h0); chk("unmapped", r, 32'h0);
    host_u.xfer(8'h02, 8'h1b, s);
    chk("cfg", O_CFG, {1'b1, 1'b1, LUI_JA_FIFO32, 1'b1});
    host_u.xfer(8'h82, 8'h00, s); chk("rd cfg", s, 8'h1b);
    chk("sdo released", O_SERIAL_READ_OUT_OE_N, 1'b1);
    chk("irq", O_IRQ, 1'b1);
    ahb(1'b0, LUI_A_STATUS, 32'h0); chk("status", r, 32'h3);
    chk("hresp", HRESP, 1'b0);
    ahb(1'b0, LUI_A_STATUS, 32'h0); chk("status clr", r, 32'h0);
    host_u.xfer(8'h00, 8'h01, s);
    @(posedge I_CLK) I_ALARM <= 2'h1;
    repeat (4) @(posedge I_CLK);
    chk("int low", O_INT_N, 1'b0);
    repeat (30) @(posedge I_CLK);
    chk("int held", O_INT_N, 1'b0);
    host_u.xfer(8'h81, 8'h00, s); chk("rd alarm", s, 8'h01);
    chk("int served", O_INT_N, 1'b1);
    host_u.xfer(8'h00, 8'h00, s);
    @(posedge I_CLK) I_ALARM <= 2'h3;
    repeat (4) @(posedge I_CLK);
    chk("int off", O_INT_N, 1'b1);
    host_u.xfer(8'h81, 8'h00, s); chk("rd alarm2", s, 8'h02);
    I_REG_RESET_N <= 1'b0;
    repeat (8) @(posedge I_CLK);
    I_REG_RESET_N <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk("cfg rst", O_CFG, 32'h0);
    host_u.xfer(8'h82, 8'h00, s); chk("rd rst", s, 8'h00);
    I_CONTROL_STYLE_STRAP <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge I_CLK);
      {I_ATTEN_PATH_SELECT, I_ATTEN_SELECT_HIGH, I_ATTEN_SELECT_LOW} <= i[2:0];
      {mute_drv, mon_drv} <= i[1:0];
      repeat (8) @(posedge I_CLK);
      chk("pin cfg", O_CFG, {i[0], i[1], i[0] ? LUI_JA_OFF :
          (i[1] ? LUI_JA_FIFO32 : LUI_JA_FIFO16), i[2]});
      chk("pin oe", {O_SERIAL_READ_OUT_OE_N, O_INT_OE_N}, 2'h3);
    end
    complete_run();
  end
endmodule
